/* File: pcd_map.vh */
// Purpose: constants for the programmable clock divider
// Assumes: 9-bit mode and divider words
// Notes: included by the store and the top module
`ifndef PCD_MAP_VH
`define PCD_MAP_VH

// ********************
// word layout
// ********************
`define PCD_WORD_W 9
`define PCD_SEL_MODE 1'b0
`define PCD_SEL_DIV 1'b1
`define PCD_SRC_BIT 0
`define PCD_DIRECT_BIT 1
`define PCD_BYPASS_BIT 2
`define PCD_PSEL_BIT 3
`define PCD_SLEEP_BIT 4
`define PCD_REFDIS_BIT 5

// ********************
// stored defaults
// ********************
`define PCD_MODE_RESET 9'h010
`define PCD_DIV_RESET 9'h000

// ********************
// divider
// ********************
`define PCD_CNT_W 10
`define PCD_DIV_OFFSET 10'h002

`endif

/* File: pcd_nvstore.v */
// Purpose: non-volatile store of the mode and divider words
// Assumes: contents survive reset; read data registered
// Notes: write allowed only when the top module says so
`timescale 1ns/1ps
`default_nettype none
`include "pcd_map.vh"

module pcd_nvstore (
  input wire clock,
  input wire ce,
  input wire write_en,
  input wire word_sel,
  input wire [8:0] write_data,
  output reg [8:0] mode_out,
  output reg [8:0] div_out,
  output reg [8:0] read_data
);
  reg [8:0] cells [0:1];

  // ********************
  // factory contents
  // ********************
  initial begin
    cells[0] = `PCD_MODE_RESET;
    cells[1] = `PCD_DIV_RESET;
    mode_out = `PCD_MODE_RESET;
    div_out = `PCD_DIV_RESET;
    read_data = `PCD_MODE_RESET;
  end

  // ********************
  // access
  // ********************
  always @(posedge clock) begin
    if (ce) begin
      if (write_en) begin
        cells[word_sel] <= write_data;
      end
      mode_out <= cells[0];
      div_out <= cells[1];
      read_data <= cells[word_sel];
    end
  end
endmodule // pcd_nvstore

`default_nettype wire

/* File: pcd_top.v */
// Purpose: clock generator with prescaler, divider, gating and power-down
// Assumes: reference and control inputs synchronous to clock
// Notes: on-chip oscillator runs at half the clock rate
//
// Summary of operation
// [RULE1] output gate high: divided clock runs at reference, prescaler, divider rate
// [RULE2] output gate low: divided clock stops low, never truncating a pulse
// [RULE3] gated off: reference keeps running, divide counter held in reset
// [RULE4] gate high again: first divided transition at the next reference rise, within one reference period
// [RULE5] sleep bit set and shared pin low: oscillator stops, power-down
// [RULE6] power-down: divided clock off, then reference pin off, then oscillator off
// [RULE7] sleep bit clear: shared pin picks source, high on-chip, low external
// [RULE8] reference pin carries mux output, ignores gate, stops cleanly at power-down
// [RULE9] reference disable bit set: reference pin permanently high impedance
// [RULE10] settings change only in programming mode, take effect after power cycle
// [RULE11] configuration held as two 9-bit stored words, mode and divider
// [RULE12] programmer writes mode word top three bits as zero
// [RULE13] source pick bit: 1 external reference, 0 on-chip oscillator
// [RULE14] direct route bit: divider bypassed, reference straight to divided pin
// [RULE15] direct route with on-chip source still applies the prescaler
// [RULE16] prescale bypass bit 1 removes prescaler, 0 inserts it
// [RULE17] prescale select 0 divides by four, 1 by two
// [RULE18] external reference never prescaled; divided by divisor or by one
// [RULE19] divisor equals stored divider value plus two
// [RULE20] reference disable bit clear: prescaled reference drives reference pin
// [RULE21] output gate sampled on reference rise, gates divider output
// [RULE22] source changeover holds outputs low, no short pulse; code holds mux output low, div_clk_out keeps its level unless direct
`timescale 1ns/1ps
`default_nettype none
`include "pcd_map.vh"

module pcd_top (
  input wire clock,
  input wire rst,
  input wire ce,
  input wire output_gate,
  input wire shared_sleep_select_pin,
  input wire ext_ref_pin,
  input wire prog_mode,
  input wire prog_write,
  input wire prog_word_sel,
  input wire [8:0] prog_data,
  output reg [8:0] prog_rdata,
  output reg div_clk_out,
  output reg div_clk_oe_n,
  output reg reference_clock_pin,
  output reg ref_clk_oe_n,
  output reg asleep
);
  // ********************
  // power sequencer states
  // ********************
  localparam [3:0] ST_RUN = 4'b0001;
  localparam [3:0] ST_OUTOFF = 4'b0010;
  localparam [3:0] ST_REFOFF = 4'b0100;
  localparam [3:0] ST_OSCOFF = 4'b1000;

  reg [3:0] state;
  reg [3:0] next_state;
  reg load_pend;
  reg cfg_loaded;
  reg prog_active;
  reg [8:0] mode_act;
  reg [8:0] div_act;
  reg [2:0] pcnt;
  reg mclk;
  reg cur_ext;
  reg switching;
  reg gate_s;
  reg [9:0] cnt;
  reg [9:0] next_cnt;
  reg next_out;

  wire [8:0] store_mode;
  wire [8:0] store_div;
  wire [8:0] store_rdata;

  // ********************
  // mode decode
  // ********************
  wire live = cfg_loaded & ~prog_active;
  wire src_bit = mode_act[`PCD_SRC_BIT];
  wire direct = mode_act[`PCD_DIRECT_BIT];
  wire bypass = mode_act[`PCD_BYPASS_BIT];
  wire psel = mode_act[`PCD_PSEL_BIT];
  wire sleep_bit = mode_act[`PCD_SLEEP_BIT];
  wire ref_dis = mode_act[`PCD_REFDIS_BIT];
  wire pd_req = live & sleep_bit & ~shared_sleep_select_pin; // [RULE5]
  wire want_ext = sleep_bit ? src_bit : ~shared_sleep_select_pin; // [RULE7] [RULE13]
  wire osc_run = live & (state != ST_OSCOFF); // [RULE3]

  // divisor and high-phase length
  wire [9:0] divisor = {1'b0, div_act} + `PCD_DIV_OFFSET; // [RULE19]
  wire [9:0] top = divisor - 10'h001;
  wire [9:0] half = (divisor + 10'h001) >> 1;

  // ********************
  // reference levels
  // ********************
  function ref_level;
    input sel_ext;
    input ext_in;
    input [2:0] osc_cnt;
    input byp;
    input sel2;
    begin
      if (sel_ext) begin
        ref_level = ext_in; // [RULE18]
      end else if (byp) begin
        ref_level = osc_cnt[0]; // [RULE16]
      end else begin
        ref_level = sel2 ? osc_cnt[1] : osc_cnt[2]; // [RULE17]
      end
    end
  endfunction

  wire cur_level = ref_level(cur_ext, ext_ref_pin, pcnt, bypass, psel);
  wire new_level = ref_level(want_ext, ext_ref_pin, pcnt, bypass, psel);
  wire hold_mclk = ~osc_run | switching | (state == ST_REFOFF); // [RULE22]
  wire next_mclk = hold_mclk ? 1'b0 : cur_level;
  wire rise = next_mclk & ~mclk;
  wire next_gate = rise ? (output_gate & (state == ST_RUN)) : gate_s; // [RULE21]

  // ********************
  // divided output path
  // ********************
  always @* begin
    next_cnt = cnt;
    next_out = div_clk_out;
    if (direct) begin
      next_cnt = top;
      next_out = next_mclk & next_gate; // [RULE14] [RULE15]
    end else if (rise) begin
      if (next_gate | div_clk_out) begin
        next_cnt = (cnt >= top) ? 10'h000 : cnt + 10'h001; // [RULE1]
        next_out = next_cnt < half;
      end else begin
        next_cnt = top; // [RULE3] [RULE4]
        next_out = 1'b0; // [RULE2]
      end
    end
  end

  // ********************
  // power sequencer
  // ********************
  always @* begin
    case (state)
      ST_RUN: begin
        next_state = pd_req ? ST_OUTOFF : ST_RUN;
      end
      ST_OUTOFF: begin
        next_state = (~gate_s & ~div_clk_out) ? ST_REFOFF : ST_OUTOFF; // [RULE6]
      end
      ST_REFOFF: begin
        next_state = ~mclk ? ST_OSCOFF : ST_REFOFF; // [RULE6] [RULE8]
      end
      ST_OSCOFF: begin
        next_state = pd_req ? ST_OSCOFF : ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // ********************
  // configuration load
  // ********************
  always @(posedge clock) begin
    if (rst) begin
      load_pend <= 1'b1;
      cfg_loaded <= 1'b0;
      prog_active <= 1'b0;
      mode_act <= `PCD_MODE_RESET;
      div_act <= `PCD_DIV_RESET;
    end else if (ce) begin
      if (load_pend) begin
        load_pend <= 1'b0;
        cfg_loaded <= 1'b1;
        prog_active <= prog_mode; // [RULE10]
        mode_act <= store_mode; // [RULE11]
        div_act <= store_div; // [RULE11]
      end
    end
  end

  // ********************
  // oscillator, mux and divider
  // ********************
  always @(posedge clock) begin
    if (rst) begin
      state <= ST_RUN;
      pcnt <= 3'h0;
      mclk <= 1'b0;
      cur_ext <= 1'b0;
      switching <= 1'b0;
      gate_s <= 1'b0;
      cnt <= 10'h000;
      div_clk_out <= 1'b0;
      div_clk_oe_n <= 1'b1;
      reference_clock_pin <= 1'b0;
      ref_clk_oe_n <= 1'b1;
      asleep <= 1'b0;
      prog_rdata <= 9'h000;
    end else if (ce) begin
      state <= live ? next_state : ST_RUN;
      if (osc_run) begin
        pcnt <= pcnt + 3'h1; // [RULE3]
      end
      if (~cfg_loaded) begin
        cur_ext <= want_ext;
      end else if (~switching) begin
        if (want_ext != cur_ext && ~mclk) begin
          switching <= 1'b1; // [RULE22]
        end
      end else if (~new_level) begin
        cur_ext <= want_ext; // [RULE22]
        switching <= 1'b0;
      end
      mclk <= next_mclk;
      gate_s <= next_gate;
      cnt <= next_cnt;
      div_clk_out <= next_out & live;
      div_clk_oe_n <= ~live | (state == ST_REFOFF) | (state == ST_OSCOFF) |
                      (next_state == ST_REFOFF); // [RULE6]
      reference_clock_pin <= next_mclk; // [RULE8] [RULE20]
      ref_clk_oe_n <= ~live | ref_dis | (state == ST_OSCOFF) |
                      (next_state == ST_OSCOFF); // [RULE9] [RULE8]
      asleep <= (state == ST_OSCOFF);
      prog_rdata <= store_rdata;
    end
  end

  // ********************
  // stored words
  // ********************
  pcd_nvstore u_store (
    .clock(clock),
    .ce(ce),
    .write_en(prog_write & prog_active & cfg_loaded), // [RULE10]
    .word_sel(prog_word_sel),
    .write_data(prog_data),
    .mode_out(store_mode),
    .div_out(store_div),
    .read_data(store_rdata)
  );
endmodule // pcd_top

`default_nettype wire

/* File: pcd_checker.sv */
// Purpose: port checker for pcd_top
// Assumes: bound from the bench
// Notes: windows sized for small divisors
`timescale 1ns/1ps
`default_nettype none
module pcd_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic output_gate,
  input wire logic shared_sleep_select_pin,
  input wire logic div_clk_out,
  input wire logic div_clk_oe_n,
  input wire logic reference_clock_pin,
  input wire logic ref_clk_oe_n,
  input wire logic asleep
);
  // ****
  // properties
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_run; output_gate && !div_clk_oe_n && shared_sleep_select_pin |-> ##[0:300] $changed(div_clk_out); endproperty
  a_run: assert property (p_run) else $error("divided clock idle");
  property p_gate; !output_gate [*8] ##1 (!output_gate && !div_clk_out) |=> !div_clk_out; endproperty
  a_gate: assert property (p_gate) else $error("gated output moved");
  property p_ref; !output_gate && !ref_clk_oe_n && shared_sleep_select_pin |-> ##[1:16] $changed(reference_clock_pin); endproperty
  a_ref: assert property (p_ref) else $error("reference stopped");
  property p_restart; !output_gate [*8] ##1 (output_gate && !div_clk_oe_n && shared_sleep_select_pin) |-> ##[1:24] $rose(div_clk_out); endproperty
  a_restart: assert property (p_restart) else $error("late restart");
  property p_cause; $rose(asleep) |-> !shared_sleep_select_pin; endproperty
  a_cause: assert property (p_cause) else $error("sleep without pin");
  property p_hiz; asleep |-> div_clk_oe_n && ref_clk_oe_n; endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven asleep");
  property p_order; $rose(ref_clk_oe_n) |-> div_clk_oe_n; endproperty
  a_order: assert property (p_order) else $error("release order");
  property p_quiet; asleep |-> !div_clk_out && !reference_clock_pin; endproperty
  a_quiet: assert property (p_quiet) else $error("output high asleep");
  cover property ($rose(asleep));
  cover property ($rose(output_gate));
  cover property ($fell(ref_clk_oe_n));
endmodule // pcd_checker
`default_nettype wire

/* File: pcd_board.sv */
// Purpose: board reference oscillator
// Assumes: free running crystal
// Notes: half period in clocks
`timescale 1ns/1ps
`default_nettype none
module pcd_board #(parameter int HALF = 3) (
  input wire logic clock,
  output var logic ext_ref_pin
);
  int c = 0;
  initial ext_ref_pin = 1'h0;
  always @(posedge clock) begin
    c <= (c == HALF - 1) ? 0 : c + 1;
    if (c == HALF - 1) ext_ref_pin <= ~ext_ref_pin;
  end
endmodule // pcd_board
`default_nettype wire

/* File: programmable_clock_divider_bench.sv */
// Purpose: self-checking bench for pcd_top
// Assumes: ce tied high
// Notes: periods in clock cycles
`timescale 1ns/1ps
`default_nettype none
module programmable_clock_divider_bench;
  localparam int H = 3;
  logic clock = 1'h0, rst = 1'h1, output_gate = 1'h1, shared_sleep_select_pin = 1'h1;
  logic prog_mode = 1'h0, prog_write = 1'h0, prog_word_sel = 1'h0;
  logic [8:0] prog_data = 9'h000, d;
  logic [8:0] tm [6] = '{9'h010, 9'h018, 9'h014, 9'h012, 9'h011, 9'h033};
  wire ext_ref_pin, div_clk_out, div_clk_oe_n, reference_clock_pin, ref_clk_oe_n, asleep;
  wire [8:0] prog_rdata;
  int mismatches = 0, check_count = 0, cyc = 0, e;
  always #20 clock = ~clock;
  pcd_board #(.HALF(H)) pcd_board_i (.clock(clock), .ext_ref_pin(ext_ref_pin));
  pcd_top pcd_top_i (.clock(clock), .rst(rst), .ce(1'h1), .output_gate(output_gate),
    .shared_sleep_select_pin(shared_sleep_select_pin), .ext_ref_pin(ext_ref_pin), .prog_mode(prog_mode),
    .prog_write(prog_write), .prog_word_sel(prog_word_sel), .prog_data(prog_data), .prog_rdata(prog_rdata),
    .div_clk_out(div_clk_out), .div_clk_oe_n(div_clk_oe_n), .reference_clock_pin(reference_clock_pin),
    .ref_clk_oe_n(ref_clk_oe_n), .asleep(asleep));
  // ****
  // tasks
  // ****
  task automatic tally_and_finish;
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [15:0] a, input logic [15:0] x);
    check_count++;
    if (a !== x) begin
      mismatches++;
      $display("Error %0t: got %0h want %0h", $time, a, x);
    end
  endtask
  task automatic per(input bit s, input int x);
    int n = 0, t = 0, r = 0;
    logic p = 1'h1, v;
    while (r < 3 && n < 9000) begin
      @(posedge clock);
      n++;
      v = s ? reference_clock_pin : div_clk_out;
      if (v === 1'h1 && p === 1'h0) begin
        r++;
        if (r == 2) t = n;
      end
      p = v;
    end
    chk(16'(n - t), 16'(x));
  endtask
  task automatic wr(input bit s, input logic [8:0] v);
    @(posedge clock);
    prog_write <= 1'h1;
    prog_word_sel <= s;
    prog_data <= v;
    @(posedge clock);
    prog_write <= 1'h0;
  endtask
  task automatic rd(input bit s, input logic [8:0] v);
    @(posedge clock);
    prog_word_sel <= s;
    repeat (4) @(posedge clock);
    chk(prog_rdata, v);
  endtask
  task automatic pwr(input bit m);
    @(posedge clock);
    rst <= 1'h1;
    prog_mode <= m;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    repeat (3) @(posedge clock);
  endtask
  task automatic cfg(input logic [8:0] m, input logic [8:0] v);
    pwr(1'h1);
    wr(1'h0, m);
    wr(1'h1, v);
    rd(1'h0, m);
    rd(1'h1, v);
    chk(div_clk_oe_n, 1'h1);
    pwr(1'h0);
  endtask
  function automatic int rp(logic [8:0] m);
    if (m[0]) return 2 * H;
    return m[2] ? 2 : (m[3] ? 4 : 8);
  endfunction
  initial begin
    e = $urandom(32'h4dca);
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    repeat (4) @(posedge clock);
    per(1'h0, 16);
    foreach (tm[i]) begin
      d = 9'($urandom % 4);
      cfg(tm[i], d);
      e = tm[i][1] ? rp(tm[i]) : rp(tm[i]) * (d + 2);
      per(1'h0, e);
      if (tm[i][5]) chk(ref_clk_oe_n, 1'h1);
      else per(1'h1, rp(tm[i]));
      wr(1'h1, d + 9'h001);
      rd(1'h1, d);
      @(posedge clock);
      output_gate <= 1'h0;
      repeat (60) @(posedge clock);
      chk(div_clk_out, 1'h0);
      output_gate <= 1'h1;
      per(1'h0, e);
    end
    cfg(9'h010, 9'h001);
    shared_sleep_select_pin <= 1'h0;
    repeat (80) @(posedge clock);
    chk({asleep, div_clk_oe_n, ref_clk_oe_n}, 3'h7);
    shared_sleep_select_pin <= 1'h1;
    repeat (80) @(posedge clock);
    chk(asleep, 1'h0);
    per(1'h0, 24);
    cfg(9'h001, 9'h000);
    per(1'h1, 8);
    shared_sleep_select_pin <= 1'h0;
    repeat (40) @(posedge clock);
    per(1'h1, 2 * H);
    tally_and_finish;
  end
endmodule // programmable_clock_divider_bench
bind pcd_top pcd_checker pcd_checker_i (.clock(clock), .rst(rst), .output_gate(output_gate),
  .shared_sleep_select_pin(shared_sleep_select_pin), .div_clk_out(div_clk_out), .div_clk_oe_n(div_clk_oe_n),
  .reference_clock_pin(reference_clock_pin), .ref_clk_oe_n(ref_clk_oe_n), .asleep(asleep));
`default_nettype wire
